// ### irq_unit_pkg.sv
// Shared constants and types for the single-vector interrupt unit
package irq_unit_pkg;

  // Register word indices and byte addresses (index times four)
  localparam logic [7:0] ENABLE_MAIN_IDX  = 8'h0b;
  localparam logic [7:0] PENDING_MAIN_IDX = 8'h0c;
  localparam logic [7:0] ENABLE_EXTRA_IDX = 8'h0d;
  localparam logic [7:0] PEND_EXTRA_IDX   = 8'h0e;
  localparam logic [7:0] OPTION_IDX       = 8'h81;
  localparam logic [9:0] ENABLE_MAIN_ADDR  = {ENABLE_MAIN_IDX, 2'b00};
  localparam logic [9:0] PENDING_MAIN_ADDR = {PENDING_MAIN_IDX, 2'b00};
  localparam logic [9:0] ENABLE_EXTRA_ADDR = {ENABLE_EXTRA_IDX, 2'b00};
  localparam logic [9:0] PEND_EXTRA_ADDR   = {PEND_EXTRA_IDX, 2'b00};
  localparam logic [9:0] OPTION_ADDR       = {OPTION_IDX, 2'b00};
  localparam logic [9:0]  CORE_STATUS_IDX  = 10'h100;
  localparam logic [11:0] CORE_STATUS_ADDR = 12'h400;

  // Field positions
  localparam int CONVERTER_BIT  = 7;
  localparam int TIMEBASE_BIT   = 6;
  localparam int TIMER_B_BIT    = 5;
  localparam int TIMER_A_BIT    = 4;
  localparam int WAKE_TIMER_BIT = 3;
  localparam int EXT_PIN_C_BIT  = 2;
  localparam int EXT_PIN_B_BIT  = 1;
  localparam int EXT_PIN_A_BIT  = 0;
  localparam int GLOBAL_EN_BIT  = 7;
  localparam int SERIAL_BIT     = 6;
  localparam int PULSE_BIT      = 1;
  localparam int LOW_SUPPLY_BIT = 0;
  localparam int EXT_PIN_A_EDGE_BIT = 6;
  localparam int EXT_PIN_B_EDGE_BIT = 5;

  // Reset values and writable masks
  localparam logic [7:0] ENABLE_MAIN_RST  = 8'h00;
  localparam logic [7:0] PENDING_MAIN_RST = 8'h00;
  localparam logic [7:0] ENABLE_EXTRA_RST = 8'h80;
  localparam logic [7:0] PEND_EXTRA_RST   = 8'h00;
  localparam logic [7:0] OPTION_RST       = 8'h00;
  localparam logic [7:0] ENABLE_EXTRA_MASK = 8'hc3;
  localparam logic [7:0] PEND_EXTRA_WMASK  = 8'h03;
  localparam logic [7:0] OPTION_MASK       = 8'h60;

  localparam logic [11:0] IRQ_VECTOR = 12'h004;
  localparam int          NUM_SOURCES = 11;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic converter_done;
    logic timebase_ovf;
    logic timer_b_ovf;
    logic timer_a_ovf;
    logic wake_timeout;
    logic pulse_rollover;
    logic low_supply;
    logic serial_tx_done;
    logic serial_rx_done;
  } event_in_s;

  typedef struct packed {
    logic instr_end;
    logic irq_return_op;
  } core_in_s;

endpackage

// ### single_vector_interrupt_unit.sv
// Single-level single-vector interrupt unit with AXI4-Lite register slave
// Behaviour
// RULE_01: Eleven sources share one level and one vector, no ordering between them.
// RULE_02: A source event sets its pending flag regardless of its enable; the code sets wake timer bit 3 only while its enable is set.
// RULE_03: A pending flag requests the core only while its enable bit is set.
// RULE_04: Request is accepted only at the end of the current instruction.
// RULE_05: Acceptance injects a long call to vector 004 and sets in-service.
// RULE_06: In-service clears in the instruction after the interrupt return.
// RULE_07: Requests are level sensitive; a set flag keeps requesting.
// RULE_08: Wake timer enable also runs the wake timer itself.
// RULE_09: Converter end of conversion sets bit 7 of main pending.
// RULE_10: Timebase overflow sets bit 6 of main pending.
// RULE_11: Timer B overflow sets bit 5, timer A overflow sets bit 4.
// RULE_12: Wake timer timeout sets bit 3 of main pending.
// RULE_13: Falling edge of pin C sets bit 2 of main pending.
// RULE_14: Selected edge of pins B and A sets bits 1 and 0.
// RULE_15: Option bit 5 set selects rising edge for pin B.
// RULE_16: Writing 0 clears a writable pending flag; writing 1 leaves it.
// RULE_17: Extra enable bit 7 is the global enable, reset to one.
// RULE_18: Extra enable bits 6, 1, 0 enable serial, pulse, low supply.
// RULE_19: Serial flag is read-only, follows transmit or receive done flags.
// RULE_20: Pulse period rollover sets bit 1 of extra pending.
// RULE_21: Low supply detection sets bit 0 of extra pending.
// RULE_22: Request is OR of enabled flags, gated globally, blocked in service.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
module single_vector_interrupt_unit (
  input  wire logic                       clk_sys_i,
  input  wire logic                       rstn_i,
  input  wire logic [11:0]                s_axi_awaddr_i,
  input  wire logic                       s_axi_awvalid_i,
  output logic                            s_axi_awready_o,
  input  wire logic [31:0]                s_axi_wdata_i,
  input  wire logic [3:0]                 s_axi_wstrb_i,
  input  wire logic                       s_axi_wvalid_i,
  output logic                            s_axi_wready_o,
  output logic [1:0]                      s_axi_bresp_o,
  output logic                            s_axi_bvalid_o,
  input  wire logic                       s_axi_bready_i,
  input  wire logic [11:0]                s_axi_araddr_i,
  input  wire logic                       s_axi_arvalid_i,
  output logic                            s_axi_arready_o,
  output logic [31:0]                     s_axi_rdata_o,
  output logic [1:0]                      s_axi_rresp_o,
  output logic                            s_axi_rvalid_o,
  input  wire logic                       s_axi_rready_i,
  input  wire irq_unit_pkg::event_in_s    events_i,
  input  wire logic                       ext_pin_a_i,
  input  wire logic                       ext_pin_b_i,
  input  wire logic                       ext_pin_c_i,
  input  wire irq_unit_pkg::core_in_s     core_i,
  output logic                            irq_request_o,
  output logic                            long_call_op_o,
  output logic [11:0]                     call_vector_o,
  output logic                            in_service_o,
  output logic                            wake_timer_run_o
);

  typedef enum logic [1:0] {
    SVC_IDLE   = 2'b00,
    SVC_ACTIVE = 2'b01,
    SVC_RETURN = 2'b10
  } svc_state_e;

  logic [7:0] enable_main_q;
  logic [7:0] pending_main_q;
  logic [7:0] enable_extra_q;
  logic [1:0] pend_extra_q;
  logic [7:0] option_q;
  logic       serial_tx_q;
  logic       serial_rx_q;
  logic [2:0] pin_prev_q;
  svc_state_e svc_q;
  svc_state_e svc_d;

  logic [11:0] awaddr_q;
  logic        aw_held_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        w_held_q;

  logic       wr_fire;
  logic [7:0] wr_byte;
  logic       wr_main_en;
  logic       wr_main_pend;
  logic       wr_extra_en;
  logic       wr_extra_pend;
  logic       wr_option;
  logic       wr_known;
  logic [7:0] main_set;
  logic [1:0] extra_set;
  logic       serial_pend;
  logic       pin_a_edge;
  logic       pin_b_edge;
  logic       pin_c_fall;
  logic       any_enabled;
  logic       accept;

  // Edge detector: rising when rise is set, falling otherwise
  function automatic logic edge_hit(input logic prev, input logic cur, input logic rise);
    edge_hit = rise ? (!prev && cur) : (prev && !cur);
  endfunction

  // Word index match: byte address bits 11:2 against a register index
  function automatic logic at_index(input logic [11:0] addr, input logic [9:0] idx);
    at_index = (addr[11:2] == idx);
  endfunction

  // ---------------- AXI4-Lite write path ----------------
  assign s_axi_awready_o = !aw_held_q && !s_axi_bvalid_o;
  assign s_axi_wready_o  = !w_held_q && !s_axi_bvalid_o;
  assign wr_fire         = aw_held_q && w_held_q && !s_axi_bvalid_o;
  assign wr_byte         = wstrb_q[0] ? wdata_q[7:0] : 8'h00;

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      aw_held_q <= 1'b0;
      awaddr_q  <= 12'h000;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_held_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr_i;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      w_held_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_held_q <= 1'b1;
      wdata_q  <= s_axi_wdata_i;
      wstrb_q  <= s_axi_wstrb_i;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  always_comb begin
    wr_main_en    = 1'b0;
    wr_main_pend  = 1'b0;
    wr_extra_en   = 1'b0;
    wr_extra_pend = 1'b0;
    wr_option     = 1'b0;
    wr_known      = 1'b1;
    if (at_index(awaddr_q, {2'b00, irq_unit_pkg::ENABLE_MAIN_IDX})) begin
      wr_main_en = wr_fire && wstrb_q[0];
    end else if (at_index(awaddr_q, {2'b00, irq_unit_pkg::PENDING_MAIN_IDX})) begin
      wr_main_pend = wr_fire && wstrb_q[0];
    end else if (at_index(awaddr_q, {2'b00, irq_unit_pkg::ENABLE_EXTRA_IDX})) begin
      wr_extra_en = wr_fire && wstrb_q[0];
    end else if (at_index(awaddr_q, {2'b00, irq_unit_pkg::PEND_EXTRA_IDX})) begin
      wr_extra_pend = wr_fire && wstrb_q[0];
    end else if (at_index(awaddr_q, {2'b00, irq_unit_pkg::OPTION_IDX})) begin
      wr_option = wr_fire && wstrb_q[0];
    end else if (at_index(awaddr_q, irq_unit_pkg::CORE_STATUS_IDX)) begin
      wr_known = 1'b1;
    end else begin
      wr_known = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= irq_unit_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= wr_known ? irq_unit_pkg::RESP_OKAY : irq_unit_pkg::RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // ---------------- AXI4-Lite read path ----------------
  assign s_axi_arready_o = !s_axi_rvalid_o;

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h0000_0000;
      s_axi_rresp_o  <= irq_unit_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o  <= irq_unit_pkg::RESP_OKAY;
      if (at_index(s_axi_araddr_i, {2'b00, irq_unit_pkg::ENABLE_MAIN_IDX})) begin
        s_axi_rdata_o <= {24'h000000, enable_main_q};
      end else if (at_index(s_axi_araddr_i, {2'b00, irq_unit_pkg::PENDING_MAIN_IDX})) begin
        s_axi_rdata_o <= {24'h000000, pending_main_q};
      end else if (at_index(s_axi_araddr_i, {2'b00, irq_unit_pkg::ENABLE_EXTRA_IDX})) begin
        s_axi_rdata_o <= {24'h000000, enable_extra_q};
      end else if (at_index(s_axi_araddr_i, {2'b00, irq_unit_pkg::PEND_EXTRA_IDX})) begin
        s_axi_rdata_o <= {24'h000000, 1'b0, serial_pend, 4'h0, pend_extra_q};
      end else if (at_index(s_axi_araddr_i, {2'b00, irq_unit_pkg::OPTION_IDX})) begin
        s_axi_rdata_o <= {24'h000000, option_q};
      end else if (at_index(s_axi_araddr_i, irq_unit_pkg::CORE_STATUS_IDX)) begin
        s_axi_rdata_o <= {28'h0000000, serial_rx_q, serial_tx_q, svc_q};
      end else begin
        s_axi_rdata_o <= 32'h0000_0000;
        s_axi_rresp_o <= irq_unit_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // ---------------- Enables and option ----------------
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      enable_main_q  <= irq_unit_pkg::ENABLE_MAIN_RST;
      enable_extra_q <= irq_unit_pkg::ENABLE_EXTRA_RST; // RULE_17
      option_q       <= irq_unit_pkg::OPTION_RST;
    end else begin
      if (wr_main_en) begin
        enable_main_q <= wr_byte;
      end
      if (wr_extra_en) begin
        enable_extra_q <= wr_byte & irq_unit_pkg::ENABLE_EXTRA_MASK; // RULE_18
      end
      if (wr_option) begin
        option_q <= wr_byte & irq_unit_pkg::OPTION_MASK;
      end
    end
  end

  assign wake_timer_run_o = enable_main_q[irq_unit_pkg::WAKE_TIMER_BIT]; // RULE_08

  // ---------------- Pin edge detection ----------------
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      pin_prev_q <= 3'b111;
    end else begin
      pin_prev_q <= {ext_pin_c_i, ext_pin_b_i, ext_pin_a_i};
    end
  end

  assign pin_c_fall = edge_hit(pin_prev_q[2], ext_pin_c_i, 1'b0); // RULE_13
  assign pin_b_edge = edge_hit(pin_prev_q[1], ext_pin_b_i,
                               option_q[irq_unit_pkg::EXT_PIN_B_EDGE_BIT]); // RULE_15
  assign pin_a_edge = edge_hit(pin_prev_q[0], ext_pin_a_i,
                               option_q[irq_unit_pkg::EXT_PIN_A_EDGE_BIT]); // RULE_14

  // ---------------- Pending flags ----------------
  assign main_set = {events_i.converter_done, // RULE_09
                     events_i.timebase_ovf,   // RULE_10
                     events_i.timer_b_ovf,    // RULE_11
                     events_i.timer_a_ovf,
                     events_i.wake_timeout && wake_timer_run_o, // RULE_12
                     pin_c_fall,
                     pin_b_edge,
                     pin_a_edge};
  assign extra_set = {events_i.pulse_rollover, events_i.low_supply}; // RULE_20 RULE_21

  // Set wins over a clearing write in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      pending_main_q <= irq_unit_pkg::PENDING_MAIN_RST;
      pend_extra_q   <= irq_unit_pkg::PEND_EXTRA_RST[1:0];
    end else begin
      pending_main_q <= ((wr_main_pend ? (pending_main_q & wr_byte) : pending_main_q)
                         | main_set); // RULE_02 RULE_16
      pend_extra_q   <= ((wr_extra_pend ? (pend_extra_q & wr_byte[1:0]) : pend_extra_q)
                         | extra_set); // RULE_16
    end
  end

  // Serial done flags live here; status bit 2 is tx, bit 3 is rx, write 0 clears
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      serial_tx_q <= 1'b0;
      serial_rx_q <= 1'b0;
    end else begin
      serial_tx_q <= events_i.serial_tx_done
                     | (serial_tx_q & !(wr_known && wr_fire && wstrb_q[0] && !wr_byte[2]
                        && at_index(awaddr_q, irq_unit_pkg::CORE_STATUS_IDX)));
      serial_rx_q <= events_i.serial_rx_done
                     | (serial_rx_q & !(wr_known && wr_fire && wstrb_q[0] && !wr_byte[3]
                        && at_index(awaddr_q, irq_unit_pkg::CORE_STATUS_IDX)));
    end
  end

  assign serial_pend = serial_tx_q | serial_rx_q; // RULE_19

  // ---------------- Request and service sequencing ----------------
  assign any_enabled = |(pending_main_q & enable_main_q)
                     | (serial_pend & enable_extra_q[irq_unit_pkg::SERIAL_BIT])
                     | |(pend_extra_q & enable_extra_q[1:0]); // RULE_01 RULE_03 RULE_07
  assign irq_request_o = any_enabled && enable_extra_q[irq_unit_pkg::GLOBAL_EN_BIT]
                       && (svc_q == SVC_IDLE); // RULE_22
  assign accept = irq_request_o && core_i.instr_end; // RULE_04

  always_comb begin
    svc_d = svc_q;
    case (svc_q)
      SVC_IDLE: begin
        if (accept) begin
          svc_d = SVC_ACTIVE; // RULE_05
        end
      end
      SVC_ACTIVE: begin
        if (core_i.instr_end && core_i.irq_return_op) begin
          svc_d = SVC_RETURN;
        end
      end
      SVC_RETURN: begin
        if (core_i.instr_end) begin
          svc_d = SVC_IDLE; // RULE_06
        end
      end
      default: begin
        svc_d = SVC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      svc_q <= SVC_IDLE;
    end else begin
      svc_q <= svc_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      long_call_op_o <= 1'b0;
      call_vector_o  <= 12'h000;
    end else begin
      long_call_op_o <= accept; // RULE_05
      call_vector_o  <= irq_unit_pkg::IRQ_VECTOR;
    end
  end

  assign in_service_o = (svc_q != SVC_IDLE);

  a_call_on_accept: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    accept |=> long_call_op_o && in_service_o && call_vector_o == 12'h004)
    else $error("accept did not raise call"); // RULE_05
  a_no_mid_instr: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    long_call_op_o |-> $past(core_i.instr_end))
    else $error("call outside instruction end"); // RULE_04
  a_block_nesting: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    in_service_o |-> !irq_request_o)
    else $error("request while in service"); // RULE_22
  a_one_instr_gap: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (svc_q == SVC_ACTIVE && core_i.instr_end && core_i.irq_return_op) |=> in_service_o)
    else $error("in service cleared at return"); // RULE_06
  a_flag_sets: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    events_i.timer_a_ovf |=> pending_main_q[4])
    else $error("timer a flag not set"); // RULE_02
  a_level_request: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (pending_main_q[0] && enable_main_q[0] && enable_extra_q[7] && svc_q == SVC_IDLE)
      |-> irq_request_o)
    else $error("enabled flag not requesting"); // RULE_07
  a_enable_gates: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !enable_extra_q[7] |-> !irq_request_o)
    else $error("request without global enable"); // RULE_17
  a_write_one_keeps: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (wr_main_pend && wr_byte == 8'hff)
      |=> (pending_main_q & $past(pending_main_q)) == $past(pending_main_q))
    else $error("write one changed flags"); // RULE_16

endmodule

// ### irq_core_model.sv
// Behavioural core sequencer that marks instruction ends and return instructions
`timescale 1ns/1ns
module irq_core_model (
  input  wire logic              clk_sys_i,
  input  wire logic              rstn_i,
  input  wire logic              ret_req_i,
  input  wire logic [1:0]        instr_len_i,
  output irq_unit_pkg::core_in_s core_o,
  output int                     ends_since_ret_o
);
  logic [1:0] cnt_q;
  logic       end_w;

  assign end_w = rstn_i && (cnt_q >= instr_len_i);

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i || end_w) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
    end
  end

  // Return qualifier toggles outside instruction ends so it is never trusted there
  always_comb begin
    core_o.instr_end     = end_w;
    core_o.irq_return_op = end_w ? ret_req_i : ~cnt_q[0];
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i || (end_w && ret_req_i)) begin
      ends_since_ret_o <= 0;
    end else if (end_w) begin
      ends_since_ret_o <= ends_since_ret_o + 1;
    end
  end
endmodule

// ### single_vector_interrupt_unit_bench.sv
// Self-checking testbench for the single-vector interrupt unit
`timescale 1ns/1ns
module single_vector_interrupt_unit_bench;
  logic                    clk_sys_i = 1'b0;
  logic                    rstn_i    = 1'b0;
  logic [11:0]             awaddr    = 12'h000;
  logic [11:0]             araddr    = 12'h000;
  logic [31:0]             wdata     = 32'h0;
  logic                    awvalid   = 1'b0;
  logic                    wvalid    = 1'b0;
  logic                    bready    = 1'b0;
  logic                    arvalid   = 1'b0;
  logic                    rready    = 1'b0;
  logic [8:0]              events    = 9'h000;
  logic                    pin_a     = 1'b1;
  logic                    pin_b     = 1'b1;
  logic                    pin_c     = 1'b1;
  logic                    ret_req   = 1'b0;
  logic [1:0]              instr_len = 2'h2;
  logic                    awready, wready, bvalid, arready, rvalid;
  logic [1:0]              bresp, rresp;
  logic [31:0]             rdata;
  logic                    irq_req, long_call, in_service, wake_run, prev_end, had_ret;
  logic [11:0]             vector;
  irq_unit_pkg::core_in_s  core;
  int                      ends_since_ret, miscompares, cmp_count, calls, seed;
  logic [33:0]             exp_q[$];
  logic [33:0]             got;
  localparam logic [11:0]  PM = {2'b00, irq_unit_pkg::PENDING_MAIN_ADDR};
  localparam logic [11:0]  PE = {2'b00, irq_unit_pkg::PEND_EXTRA_ADDR};
  localparam logic [11:0]  EM = {2'b00, irq_unit_pkg::ENABLE_MAIN_ADDR};
  localparam logic [11:0]  EE = {2'b00, irq_unit_pkg::ENABLE_EXTRA_ADDR};
  localparam logic [1:0]   OK = irq_unit_pkg::RESP_OKAY;

  always #4 clk_sys_i = ~clk_sys_i;

  single_vector_interrupt_unit single_vector_interrupt_unit_inst (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .events_i(events),
    .ext_pin_a_i(pin_a), .ext_pin_b_i(pin_b), .ext_pin_c_i(pin_c), .core_i(core),
    .irq_request_o(irq_req), .long_call_op_o(long_call), .call_vector_o(vector),
    .in_service_o(in_service), .wake_timer_run_o(wake_run)
  );

  irq_core_model irq_core_model_inst (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ret_req_i(ret_req), .instr_len_i(instr_len),
    .core_o(core), .ends_since_ret_o(ends_since_ret)
  );

  task automatic check(input logic ok, input string what);
    cmp_count++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("ERROR t=%0t %s", $time, what);
    end
  endtask

  task automatic axi_write(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    check(bvalid && bresp === er, "write response");
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    exp_q.push_back({er, 24'h0, d});
    do begin
      @(posedge clk_sys_i);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    check(n < 100, "read timeout");
    rready <= 1'b0;
  endtask

  task automatic pulse(input logic [8:0] e);
    @(posedge clk_sys_i);
    events <= e;
    @(posedge clk_sys_i);
    events <= 9'h000;
  endtask

  task automatic wait_calls(input int n);
    int k;
    k = 0;
    while (calls < n && k < 200) begin
      @(posedge clk_sys_i);
      k++;
    end
    check(calls == n, "call count");
  endtask

  task automatic do_return();
    int n;
    n = 0;
    @(posedge clk_sys_i);
    ret_req <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (!(core.instr_end && core.irq_return_op) && n < 100);
    ret_req <= 1'b0;
    had_ret = 1'b1;
  endtask

  task automatic finish_test();
    $display("miscompares=%0d cmp_count=%0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Result watcher: read data against queued notes, injected calls against their cause
  always @(posedge clk_sys_i) begin
    if (rvalid && rready) begin
      got = (exp_q.size() > 0) ? exp_q.pop_front() : 34'h3ffffffff;
      check({rresp, rdata} === got, "read data");
    end
    if (long_call === 1'b1) begin
      calls++;
      check(prev_end && vector === irq_unit_pkg::IRQ_VECTOR && in_service, "call");
      check(!had_ret || ends_since_ret >= 2, "gap after return");
    end
    if (in_service && irq_req) check(1'b0, "request while in service");
    prev_end <= core.instr_end && irq_req;
  end

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    miscompares++;
    $display("ERROR t=%0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    logic [7:0] em, ex, pin_exp[4];
    logic [31:0] rnd;
    pin_exp = '{8'h07, 8'h00, 8'h04, 8'h03};
    seed = 32'hfc2f;
    had_ret = 1'b0;
    repeat (20) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    axi_read(EM, 8'h00, OK);
    axi_read(PM, 8'h00, OK);
    axi_read(EE, 8'h80, OK);
    axi_read(PE, 8'h00, OK);
    axi_read(12'h3f0, 8'h00, irq_unit_pkg::RESP_SLVERR);
    axi_write(12'h3f0, 8'hff, irq_unit_pkg::RESP_SLVERR);
    for (int i = 0; i < 3; i++) begin
      rnd = $random(seed);
      axi_write(EM, rnd[7:0], OK);
      axi_read(EM, rnd[7:0], OK);
      check(wake_run === rnd[3], "wake run");
      axi_write(EE, rnd[7:0], OK);
      axi_read(EE, rnd[7:0] & irq_unit_pkg::ENABLE_EXTRA_MASK, OK);
    end
    axi_write(EE, 8'h00, OK);
    axi_write(EM, 8'h00, OK);
    pulse(9'h010);
    axi_read(PM, 8'h00, OK);
    axi_write(EM, 8'h08, OK);
    for (int i = 0; i < 9; i++) begin
      pulse(9'h001 << i);
      em = (i >= 4) ? 8'h01 << (i - 1) : 8'h00;
      ex = (i == 3) ? 8'h02 : (i == 2) ? 8'h01 : (i < 2) ? 8'h40 : 8'h00;
      axi_write(PM, 8'hff, OK);
      axi_write(PE, 8'hff, OK);
      axi_read(PM, em, OK);
      axi_read(PE, ex, OK);
      check(irq_req === 1'b0, "request with global enable off");
      axi_write(PM, 8'h00, OK);
      axi_write(PE, 8'h00, OK);
      axi_read(PE, ex & 8'h40, OK);
      axi_write(irq_unit_pkg::CORE_STATUS_ADDR, 8'h00, OK);
      axi_read(PE, 8'h00, OK);
    end
    for (int k = 0; k < 4; k++) begin
      if (k == 2) axi_write({2'b00, irq_unit_pkg::OPTION_ADDR}, 8'h60, OK);
      @(posedge clk_sys_i);
      {pin_a, pin_b, pin_c} <= {3{k[0]}};
      axi_read(PM, pin_exp[k], OK);
      axi_write(PM, 8'h00, OK);
    end
    rnd = $random(seed);
    instr_len <= rnd[1:0];
    axi_write(EM, 8'h10, OK);
    axi_write(EE, 8'h80, OK);
    pulse(9'h020);
    wait_calls(1);
    do_return();
    wait_calls(2);
    axi_write(PM, 8'h00, OK);
    do_return();
    repeat (30) @(posedge clk_sys_i);
    check(calls == 2 && in_service === 1'b0, "service ended");
    axi_write(EM, 8'h00, OK);
    axi_write(EE, 8'h81, OK);
    pulse(9'h020);
    @(posedge clk_sys_i);
    check(irq_req === 1'b0, "request from disabled source");
    pulse(9'h004);
    wait_calls(3);
    axi_write(PE, 8'h00, OK);
    do_return();
    repeat (30) @(posedge clk_sys_i);
    check(calls == 3 && irq_req === 1'b0, "quiet after clear");
    finish_test();
  end
endmodule
